// file: osc_select_params.svh
// Encodings, field codes and widths for the oscillator mode select block
`ifndef OSC_SELECT_PARAMS_SVH
`define OSC_SELECT_PARAMS_SVH

`define OSC_CFG_W            4
`define OSC_FREQ_W           3
`define OSC_CODE_FAST_X4     4'h6
`define OSC_CODE_INT_PIN_IO  4'h8
`define OSC_CODE_INT_CLKOUT  4'h9
`define OSC_CODE_LP_DEF      4'h0
`define OSC_CODE_XT_DEF      4'h1
`define OSC_CODE_HS_DEF      4'h2
`define OSC_CODE_RC_DEF      4'h3
`define OSC_CODE_EC_DEF      4'h4
`define OSC_CODE_EXT_CLOCK_PIN_IO_MODE_DEF    4'h5
`define OSC_CODE_RESISTOR_CAP_MODE_PIN_IO_DEF    4'h7
`define OSC_FREQ_31K         3'h0
`define OSC_FREQ_4M          3'h6
`define OSC_FREQ_8M          3'h7
`define OSC_FREQ_TOP         4'h7
`define OSC_DIV_256_LOG2     4'h8
`define OSC_DIV_CNT_W        8
`define OSC_SYNC_STAGES      3

`endif

// file: osc_select_pkg.sv
// Types shared by the oscillator mode select block
package osc_select_pkg;

  typedef enum logic [3:0] {
    low_power_crystal_mode   = 4'h0,
    standard_crystal_mode    = 4'h1,
    high_speed_crystal_mode  = 4'h2,
    fast_crystal_x4_mode     = 4'h3,
    resistor_cap_mode_clkout = 4'h4,
    resistor_cap_mode_pin_io = 4'h5,
    internal_osc_clkout_mode = 4'h6,
    internal_osc_pin_io_mode = 4'h7,
    ext_clock_clkout_mode    = 4'h8,
    ext_clock_pin_io_mode    = 4'h9
  } osc_mode_t;

  typedef enum logic [1:0] {
    src_none   = 2'h0,
    src_pin    = 2'h1,
    src_slow   = 2'h2,
    src_fast   = 2'h3
  } clk_src_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic pwrt;
    logic fscm;
    logic wdt;
    logic two_speed;
  } slow_users_t;

endpackage

// file: tick_divider.sv
// Power-of-two tick postscaler that only retimes at a period boundary
`timescale 1ns/1ps
`include "osc_select_params.svh"

module tick_divider #(
  parameter int CNT_W = `OSC_DIV_CNT_W
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic [3:0] ratio_log2,
  output logic            tick_out
);

  if (CNT_W < 8 || CNT_W > 15) begin : g_bad_width
    $error("tick_divider: CNT_W must lie in 8..15");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [3:0]       shift;
    logic             out;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [CNT_W:0] limit;

  always_comb begin
    s_d   = s_q;
    limit = ({{CNT_W{1'b0}}, 1'b1} << s_q.shift) - {{CNT_W{1'b0}}, 1'b1};
    s_d.out = 1'b0;
    if (tick_in) begin
      // New ratio only at wrap, so no pulse is ever cut short
      if ({1'b0, s_q.cnt} >= limit) begin // [RL24]
        s_d.cnt   = '0;
        s_d.out   = 1'b1;
        s_d.shift = ratio_log2;
      end else begin
        s_d.cnt = s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.out;

  a_div_no_runt: assert property (@(posedge clock) disable iff (!rst_n) // [RL24]
    (s_q.out && s_q.shift != 4'h0) |=> !s_q.out)
    else $error("postscaler pulses back to back at a ratio above one");

endmodule // tick_divider

// file: osc_mode_select.sv
// Oscillator mode decode, pin ownership, internal clock select and multiplier gating
`timescale 1ns/1ps
`include "osc_select_params.svh"

// Overview of operation
// [RL1] Ten oscillator modes from four-bit configuration field
// [RL2] Internal modes: pin six clock-out or I/O
// [RL3] Crystal modes dedicate both oscillator pins
// [RL4] External clock: input pin, no start-up delay
// [RL5] External clock-out mode drives clock over four
// [RL6] External pin-I/O mode frees output as bit six
// [RL7] RC clock-out mode drives clock over four
// [RL8] RC pin-I/O mode frees output as bit six
// [RL9] Fast crystal times four, up to forty megahertz
// [RL10] Software multiplier bit unavailable in crystal-x4 mode
// [RL11] Crystal multiplier only with the x4 encoding
// [RL12] Internal modes: software enables multiplier, 32 MHz
// [RL13] Two internal sources, either selectable as clock
// [RL14] Fast source direct or through postscaler
// [RL15] Fast source on for 125 kHz to 8 MHz
// [RL16] Slow source on when selected as clock
// [RL17] Slow source on for timer, monitor, watchdog, start-up
// [RL18] Frequency field picks fast, slow or postscaled
// [RL19] Internal multiplier only in the two internal modes
// [RL20] Internal multiplier only at 4 or 8 MHz
// [RL21] Multiplier bit forced and read as zero elsewhere
// [RL22] 31 kHz option: origin bit picks source
// [RL23] Other mode encodings come from a parameter table
// [RL24] Mode fixed at reset; switching without runt pulses
module osc_mode_select #(
  parameter logic [3:0] CODE_LP   = `OSC_CODE_LP_DEF,
  parameter logic [3:0] CODE_XT   = `OSC_CODE_XT_DEF,
  parameter logic [3:0] CODE_HS   = `OSC_CODE_HS_DEF,
  parameter logic [3:0] CODE_RC   = `OSC_CODE_RC_DEF,
  parameter logic [3:0] CODE_RESISTOR_CAP_MODE_PIN_IO = `OSC_CODE_RESISTOR_CAP_MODE_PIN_IO_DEF,
  parameter logic [3:0] CODE_EC   = `OSC_CODE_EC_DEF,
  parameter logic [3:0] CODE_EXT_CLOCK_PIN_IO_MODE = `OSC_CODE_EXT_CLOCK_PIN_IO_MODE_DEF
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [`OSC_CFG_W-1:0]      osc_mode_cfg_field,
  input  wire logic [`OSC_FREQ_W-1:0]     internal_freq_field,
  input  wire logic                       low_freq_origin_bit,
  input  wire logic                       multiplier_enable_bit,
  input  wire osc_select_pkg::slow_users_t slow_users,
  input  wire logic                       fast_osc_tick,
  input  wire logic                       slow_osc_tick,
  input  wire logic                       osc_in_pin_i,
  input  wire logic                       osc_out_pin_i,
  input  wire osc_select_pkg::pin_drive_t port_a_bit_six_drive,
  input  wire osc_select_pkg::pin_drive_t port_a_bit_seven_drive,
  output osc_select_pkg::osc_mode_t       osc_mode,
  output osc_select_pkg::clk_src_t        clk_source,
  output logic                            dev_clk_tick,
  output logic                            multiplier_active,
  output logic                            multiplier_enable_rd,
  output logic                            fast_osc_enable,
  output logic                            slow_osc_enable,
  output logic                            startup_delay_needed,
  output logic                            osc_out_pin_o,
  output logic                            osc_out_pin_oe,
  output logic                            osc_in_pin_o,
  output logic                            osc_in_pin_oe,
  output logic                            port_a_bit_six_gpio,
  output logic                            port_a_bit_seven_gpio,
  output logic                            port_a_bit_six_in,
  output logic                            port_a_bit_seven_in
);

  if (CODE_LP == `OSC_CODE_FAST_X4 || CODE_XT == `OSC_CODE_FAST_X4 || CODE_HS == `OSC_CODE_FAST_X4 ||
      CODE_RC == `OSC_CODE_INT_PIN_IO || CODE_EC == `OSC_CODE_INT_CLKOUT) begin : g_bad_codes
    $error("osc_mode_select: mode code clashes with a fixed encoding");
  end

  typedef struct packed {
    logic                      loaded;
    osc_select_pkg::osc_mode_t mode;
    logic [2:0]                sync_in;
    logic [2:0]                sync_out;
    logic                      lvl_in;
    logic                      lvl_out;
    logic [`OSC_FREQ_W-1:0]    freq;
    logic                      origin;
    osc_select_pkg::clk_src_t  src;
    logic                      tick;
    logic                      clk_div;
    logic                      clkout;
    logic                      mult;
    logic                      mult_rd;
    logic                      fast_en;
    logic                      slow_en;
    logic                      startup;
    logic                      out_o;
    logic                      out_oe;
    logic                      in_o;
    logic                      in_oe;
    logic                      ra6_gpio;
    logic                      ra7_gpio;
  } sel_state_t;

  sel_state_t s_q;
  sel_state_t s_d;
  logic       post_tick;
  logic [3:0] post_log2;
  logic       pin_tick;
  logic       want_fast;
  logic       is_int;
  logic       is_xtal;
  logic       is_ext;
  logic       is_clkout;
  logic       is_ra6_io;
  logic       src_tick;
  osc_select_pkg::clk_src_t want_src;

  function automatic osc_select_pkg::osc_mode_t decode_mode(input logic [3:0] code);
    osc_select_pkg::osc_mode_t m;
    m = osc_select_pkg::low_power_crystal_mode;
    if (code == `OSC_CODE_FAST_X4)      m = osc_select_pkg::fast_crystal_x4_mode; // [RL11]
    else if (code == `OSC_CODE_INT_CLKOUT) m = osc_select_pkg::internal_osc_clkout_mode;
    else if (code == `OSC_CODE_INT_PIN_IO) m = osc_select_pkg::internal_osc_pin_io_mode;
    else if (code == CODE_XT)            m = osc_select_pkg::standard_crystal_mode; // [RL23]
    else if (code == CODE_HS)            m = osc_select_pkg::high_speed_crystal_mode;
    else if (code == CODE_RC)            m = osc_select_pkg::resistor_cap_mode_clkout;
    else if (code == CODE_RESISTOR_CAP_MODE_PIN_IO)          m = osc_select_pkg::resistor_cap_mode_pin_io;
    else if (code == CODE_EC)            m = osc_select_pkg::ext_clock_clkout_mode;
    else if (code == CODE_EXT_CLOCK_PIN_IO_MODE)          m = osc_select_pkg::ext_clock_pin_io_mode;
    return m;
  endfunction

  // Postscaled fast source: 8 MHz over two to the power of the distance from the top code, over 256 at code 0
  assign post_log2 = (s_q.freq == `OSC_FREQ_31K) ? `OSC_DIV_256_LOG2
                                                  : (`OSC_FREQ_TOP - {1'b0, s_q.freq}); // [RL14] [RL22]

  // No ratio is taken before the frequency field is first registered
  tick_divider #(
    .CNT_W      (`OSC_DIV_CNT_W)
  ) u_postscaler (
    .clock      (clock),
    .rst_n      (rst_n),
    .tick_in    (fast_osc_tick && s_q.loaded),
    .ratio_log2 (post_log2),
    .tick_out   (post_tick)
  );

  always_comb begin
    s_d       = s_q;
    is_int    = 1'b0;
    is_xtal   = 1'b0;
    is_ext    = 1'b0;
    is_clkout = 1'b0;
    is_ra6_io = 1'b0;
    case (s_q.mode) // [RL1]
      osc_select_pkg::low_power_crystal_mode,
      osc_select_pkg::standard_crystal_mode,
      osc_select_pkg::high_speed_crystal_mode,
      osc_select_pkg::fast_crystal_x4_mode:     is_xtal = 1'b1;
      osc_select_pkg::resistor_cap_mode_clkout: is_clkout = 1'b1;
      osc_select_pkg::resistor_cap_mode_pin_io: is_ra6_io = 1'b1;
      osc_select_pkg::internal_osc_clkout_mode: begin
        is_int    = 1'b1;
        is_clkout = 1'b1;
      end
      osc_select_pkg::internal_osc_pin_io_mode: begin
        is_int    = 1'b1;
        is_ra6_io = 1'b1;
      end
      osc_select_pkg::ext_clock_clkout_mode: begin
        is_ext    = 1'b1;
        is_clkout = 1'b1;
      end
      osc_select_pkg::ext_clock_pin_io_mode: begin
        is_ext    = 1'b1;
        is_ra6_io = 1'b1;
      end
      default: is_xtal = 1'b1;
    endcase

    // Mode is sampled once after reset release; straps never follow the pin later
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.mode   = decode_mode(osc_mode_cfg_field); // [RL24]
    end

    // Pin filters: a level change counts once stages two and three agree
    s_d.sync_in  = {s_q.sync_in[1:0], osc_in_pin_i};
    s_d.sync_out = {s_q.sync_out[1:0], osc_out_pin_i};
    if (s_q.sync_in[1] == s_q.sync_in[2]) begin
      s_d.lvl_in = s_q.sync_in[2];
    end
    if (s_q.sync_out[1] == s_q.sync_out[2]) begin
      s_d.lvl_out = s_q.sync_out[2];
    end
    pin_tick = s_d.lvl_in && !s_q.lvl_in;

    s_d.freq   = internal_freq_field;
    s_d.origin = low_freq_origin_bit;

    // Source wanted now; fast covers direct 8 MHz, postscaled and divide-by-256
    want_fast = (s_q.freq != `OSC_FREQ_31K) || s_q.origin; // [RL18] [RL22]
    if (!s_q.loaded) begin
      want_src = osc_select_pkg::src_none;
    end else if (!is_int) begin
      want_src = osc_select_pkg::src_pin; // [RL4]
    end else if (want_fast) begin
      want_src = osc_select_pkg::src_fast; // [RL13]
    end else begin
      want_src = osc_select_pkg::src_slow; // [RL13]
    end

    case (s_q.src)
      osc_select_pkg::src_pin:  src_tick = pin_tick;
      osc_select_pkg::src_slow: src_tick = slow_osc_tick;
      osc_select_pkg::src_fast: src_tick = post_tick;
      default:                  src_tick = 1'b0;
    endcase
    s_d.tick = src_tick;
    // Switch sources only on a tick of the old one so no half period escapes
    if (s_q.src == osc_select_pkg::src_none || src_tick) begin
      s_d.src = want_src; // [RL24]
    end

    // Clock over four: toggle the output pin every second device tick
    if (s_q.tick) begin
      s_d.clk_div = !s_q.clk_div;
      if (s_q.clk_div) begin
        s_d.clkout = !s_q.clkout; // [RL5] [RL7]
      end
    end

    // Internal multiplier needs an internal mode and 4 or 8 MHz selected
    s_d.mult_rd = is_int && multiplier_enable_bit; // [RL19] [RL21] [RL10]
    s_d.mult    = (s_q.mode == osc_select_pkg::fast_crystal_x4_mode) || // [RL9] [RL11]
                  (s_d.mult_rd && (s_q.freq == `OSC_FREQ_8M || s_q.freq == `OSC_FREQ_4M)); // [RL12] [RL20]

    // The running source stays powered until a switch away from it has landed
    s_d.fast_en = (is_int && want_fast) || (s_q.src == osc_select_pkg::src_fast); // [RL15]
    s_d.slow_en = (is_int && !want_fast) || (s_q.src == osc_select_pkg::src_slow) || // [RL16]
                  slow_users.pwrt || slow_users.fscm || slow_users.wdt || slow_users.two_speed; // [RL17]
    s_d.startup = is_xtal; // [RL4]

    // Pin ownership per mode
    s_d.ra6_gpio = is_ra6_io; // [RL6] [RL8] [RL2]
    s_d.ra7_gpio = is_int; // [RL2]
    if (is_xtal) begin
      s_d.out_o  = 1'b0; // [RL3]
      s_d.out_oe = 1'b0;
    end else if (is_clkout) begin
      s_d.out_o  = s_q.clkout; // [RL5] [RL7] [RL2]
      s_d.out_oe = 1'b1;
    end else begin
      s_d.out_o  = port_a_bit_six_drive.out; // [RL6] [RL8]
      s_d.out_oe = port_a_bit_six_drive.oe;
    end
    if (is_int) begin
      s_d.in_o  = port_a_bit_seven_drive.out; // [RL2]
      s_d.in_oe = port_a_bit_seven_drive.oe;
    end else begin
      s_d.in_o  = 1'b0; // [RL3] [RL4]
      s_d.in_oe = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign osc_mode              = s_q.mode;
  assign clk_source            = s_q.src;
  assign dev_clk_tick          = s_q.tick;
  assign multiplier_active     = s_q.mult;
  assign multiplier_enable_rd  = s_q.mult_rd;
  assign fast_osc_enable       = s_q.fast_en;
  assign slow_osc_enable       = s_q.slow_en;
  assign startup_delay_needed  = s_q.startup;
  assign osc_out_pin_o         = s_q.out_o;
  assign osc_out_pin_oe        = s_q.out_oe;
  assign osc_in_pin_o          = s_q.in_o;
  assign osc_in_pin_oe         = s_q.in_oe;
  assign port_a_bit_six_gpio   = s_q.ra6_gpio;
  assign port_a_bit_seven_gpio = s_q.ra7_gpio;
  assign port_a_bit_six_in     = s_q.lvl_out;
  assign port_a_bit_seven_in   = s_q.lvl_in;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_mode_frozen: assert property (s_q.loaded |=> $stable(s_q.mode)) // [RL24]
    else $error("oscillator mode changed after it was loaded");
  a_x4_crystal_on: assert property ( // [RL11]
    (s_q.mode == osc_select_pkg::fast_crystal_x4_mode) |=> s_q.mult && !s_q.mult_rd)
    else $error("crystal x4 mode without multiplier or with readable enable bit");
  a_mult_bit_zero: assert property ( // [RL21]
    (!(s_q.mode inside {osc_select_pkg::internal_osc_clkout_mode, osc_select_pkg::internal_osc_pin_io_mode}))
    |=> !s_q.mult_rd)
    else $error("multiplier enable reads one outside internal modes");
  a_mult_freq_gate: assert property ( // [RL20]
    (s_q.mult && s_q.mode != osc_select_pkg::fast_crystal_x4_mode) |-> $past(s_q.freq) inside {3'h6, 3'h7})
    else $error("internal multiplier active at a frequency other than 4 or 8 MHz");
  a_xtal_pins_held: assert property ( // [RL3]
    (s_q.loaded && s_q.mode inside {osc_select_pkg::low_power_crystal_mode, osc_select_pkg::standard_crystal_mode,
     osc_select_pkg::high_speed_crystal_mode, osc_select_pkg::fast_crystal_x4_mode})
    |=> !s_q.out_oe && !s_q.in_oe && !s_q.ra6_gpio && !s_q.ra7_gpio && s_q.startup)
    else $error("crystal pins released or start-up delay missing");
  a_ext_no_delay: assert property ( // [RL4]
    (s_q.mode inside {osc_select_pkg::ext_clock_clkout_mode, osc_select_pkg::ext_clock_pin_io_mode})
    |=> !s_q.startup ##1 (s_q.src == osc_select_pkg::src_pin))
    else $error("external clock mode asks for start-up delay or wrong source");
  a_clkout_follow: assert property ( // [RL5]
    (s_q.mode inside {osc_select_pkg::ext_clock_clkout_mode, osc_select_pkg::resistor_cap_mode_clkout,
     osc_select_pkg::internal_osc_clkout_mode}) |=> s_q.out_oe && (s_q.out_o == $past(s_q.clkout)))
    else $error("clock-out pin not driven with clock over four");
  a_ra6_freed: assert property ( // [RL6]
    (s_q.mode inside {osc_select_pkg::ext_clock_pin_io_mode, osc_select_pkg::resistor_cap_mode_pin_io,
     osc_select_pkg::internal_osc_pin_io_mode}) |=> s_q.ra6_gpio && s_q.out_oe == $past(port_a_bit_six_drive.oe))
    else $error("pin six not handed to general I/O");
  a_slow_auto_on: assert property ( // [RL17]
    (slow_users.wdt || slow_users.pwrt || slow_users.fscm || slow_users.two_speed) |=> s_q.slow_en)
    else $error("slow oscillator off while a dependent feature is on");
  a_fast_range_on: assert property ( // [RL15]
    (s_q.mode inside {osc_select_pkg::internal_osc_clkout_mode, osc_select_pkg::internal_osc_pin_io_mode}
     && s_q.freq != 3'h0) |=> s_q.fast_en)
    else $error("fast oscillator off with 125 kHz to 8 MHz selected");
  a_clkout_quarter: assert property ( // [RL7]
    (s_q.tick && s_q.clk_div) |=> (s_q.clkout != $past(s_q.clkout)))
    else $error("clock-out did not toggle on every second tick");

  a_int_pins_io: assert property ( // [RL2]
    (s_q.mode inside {osc_select_pkg::internal_osc_clkout_mode, osc_select_pkg::internal_osc_pin_io_mode})
    |=> s_q.ra7_gpio && s_q.in_oe == $past(port_a_bit_seven_drive.oe))
    else $error("pin seven not handed to general I/O");
  a_live_fast_src: assert property ((s_q.src == osc_select_pkg::src_fast) |=> s_q.fast_en) // [RL15]
    else $error("fast oscillator off while it clocks the device");
  a_live_slow_src: assert property ((s_q.src == osc_select_pkg::src_slow) |=> s_q.slow_en) // [RL16]
    else $error("slow oscillator off while it clocks the device");
  a_src_chosen: assert property (s_q.loaded |=> s_q.src != osc_select_pkg::src_none) // [RL24]
    else $error("no clock source chosen after the mode was loaded");

  c_x4_crystal: cover property (s_q.loaded && s_q.mode == osc_select_pkg::fast_crystal_x4_mode && s_q.mult);
  c_int_mult_8m: cover property (s_q.mult && s_q.freq == 3'h7 && s_q.ra7_gpio);
  c_slow_to_fast: cover property ((s_q.src == osc_select_pkg::src_slow) ##1 (s_q.src == osc_select_pkg::src_fast));
  c_div256: cover property (s_q.src == osc_select_pkg::src_fast && s_q.freq == 3'h0 && s_q.tick);
  c_fast_to_slow: cover property ((s_q.src == osc_select_pkg::src_fast) ##1 (s_q.src == osc_select_pkg::src_slow));

endmodule // osc_mode_select

// file: osc_source_model.sv
// Free-running fast, slow and pin clock sources for the oscillator select block
`timescale 1ns/1ps
module osc_source_model #(
  parameter int FAST_DIV = 12,
  parameter int SLOW_DIV = 40,
  parameter int PIN_HALF = 8
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      fast_tick,
  output logic      slow_tick,
  output logic      pin_clk
);
  int fast_cnt_q;
  int slow_cnt_q;
  int pin_cnt_q;

  // Sources never pause between uses, so a switch can land anywhere in a period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_q <= 0;
      slow_cnt_q <= 0;
      pin_cnt_q  <= 0;
      fast_tick  <= 1'b0;
      slow_tick  <= 1'b0;
      pin_clk    <= 1'b0;
    end else begin
      fast_cnt_q <= (fast_cnt_q == FAST_DIV - 1) ? 0 : fast_cnt_q + 1;
      fast_tick  <= (fast_cnt_q == FAST_DIV - 1);
      slow_cnt_q <= (slow_cnt_q == SLOW_DIV - 1) ? 0 : slow_cnt_q + 1;
      slow_tick  <= (slow_cnt_q == SLOW_DIV - 1);
      pin_cnt_q  <= (pin_cnt_q == PIN_HALF - 1) ? 0 : pin_cnt_q + 1;
      if (pin_cnt_q == PIN_HALF - 1) begin
        pin_clk <= ~pin_clk;
      end
    end
  end
endmodule // osc_source_model

// file: osc_mode_select_tb.sv
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
module osc_mode_select_tb;
  localparam int FAST_DIV = 12;
  localparam int SLOW_DIV = 40;
  localparam int PIN_HALF = 8;
  // Strap code to decoded mode
  localparam logic [3:0] MODE_OF [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'h3, 4'h5, 4'h7, 4'h6};

  logic                       clock       = 1'b0;
  logic                       rst_n       = 1'b0;
  logic [3:0]                 strap       = 4'h0;
  logic [2:0]                 freq        = 3'h7;
  logic                       origin      = 1'b0;
  logic                       mult_en     = 1'b1;
  osc_select_pkg::slow_users_t users      = '0;
  osc_select_pkg::pin_drive_t six_drive   = '{out: 1'b1, oe: 1'b0};
  osc_select_pkg::pin_drive_t seven_drive = '{out: 1'b1, oe: 1'b1};
  logic                       six_level   = 1'b1;
  logic                       fast_tick;
  logic                       slow_tick;
  logic                       pin_clk;
  wire logic                  osc_in_wire;
  wire logic                  osc_out_wire;
  osc_select_pkg::osc_mode_t  osc_mode;
  osc_select_pkg::clk_src_t   clk_source;
  logic                       dev_clk_tick, multiplier_active, multiplier_enable_rd;
  logic                       fast_osc_enable, slow_osc_enable, startup_delay_needed;
  logic                       osc_out_pin_o, osc_out_pin_oe, osc_in_pin_o, osc_in_pin_oe;
  logic                       port_a_bit_six_gpio, port_a_bit_seven_gpio;
  logic                       port_a_bit_six_in, port_a_bit_seven_in;
  int                         mismatches  = 0;
  int                         checks_done = 0;

  always #5 clock = ~clock;

  // Pin level from whoever drives it; the bench holds pin six when released
  assign osc_in_wire  = osc_in_pin_oe ? osc_in_pin_o : pin_clk;
  assign osc_out_wire = osc_out_pin_oe ? osc_out_pin_o : six_level;

  osc_source_model #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV), .PIN_HALF(PIN_HALF)) src (
    .clock(clock), .rst_n(rst_n), .fast_tick(fast_tick), .slow_tick(slow_tick), .pin_clk(pin_clk));

  osc_mode_select DUT (
    .clock(clock), .rst_n(rst_n), .osc_mode_cfg_field(strap), .internal_freq_field(freq),
    .low_freq_origin_bit(origin), .multiplier_enable_bit(mult_en), .slow_users(users),
    .fast_osc_tick(fast_tick), .slow_osc_tick(slow_tick), .osc_in_pin_i(osc_in_wire),
    .osc_out_pin_i(osc_out_wire), .port_a_bit_six_drive(six_drive), .port_a_bit_seven_drive(seven_drive),
    .osc_mode(osc_mode), .clk_source(clk_source), .dev_clk_tick(dev_clk_tick),
    .multiplier_active(multiplier_active), .multiplier_enable_rd(multiplier_enable_rd),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .startup_delay_needed(startup_delay_needed), .osc_out_pin_o(osc_out_pin_o),
    .osc_out_pin_oe(osc_out_pin_oe), .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe(osc_in_pin_oe),
    .port_a_bit_six_gpio(port_a_bit_six_gpio), .port_a_bit_seven_gpio(port_a_bit_seven_gpio),
    .port_a_bit_six_in(port_a_bit_six_in), .port_a_bit_seven_in(port_a_bit_seven_in));

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic fail_wait(input string name);
    mismatches++;
    $display("Error %s expected event seen none", name);
    end_sim();
  endtask

  task automatic boot(input logic [3:0] code);
    @(posedge clock);
    rst_n <= 1'b0;
    strap <= code;
    repeat (10) @(posedge clock);
    check("reset_mode", 16'h0, 16'(osc_mode));
    check("reset_source", 16'h0, 16'(clk_source));
    rst_n <= 1'b1;
    repeat (30) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic wait_src(input osc_select_pkg::clk_src_t exp);
    int n;
    for (n = 0; n < 5000 && clk_source !== exp; n++) @(negedge clock);
    if (n == 5000) fail_wait("clk_source");
  endtask

  // Skips the first rise: a switch may leave one stretched period behind
  task automatic measure(input bit sel, input int exp, input string name);
    int   n;
    int   t1;
    int   p;
    int   rises;
    logic prev;
    logic cur;
    prev  = 1'b1;
    rises = 0;
    t1    = 0;
    p     = 0;
    for (n = 0; n < 12000 && rises < 3; n++) begin
      @(negedge clock);
      cur = sel ? osc_out_pin_o : dev_clk_tick;
      if (cur && !prev) begin
        rises++;
        if (rises == 2) t1 = n;
        if (rises == 3) p = n - t1;
      end
      prev = cur;
    end
    if (rises < 3) fail_wait(name);
    check(name, 16'(exp), 16'(p));
  endtask

  initial begin
    int i;
    int f;
    int m;
    // Strap codes 0 to 9, multiplier bit requested
    for (i = 0; i < 10; i++) begin
      boot(4'(i));
      m = MODE_OF[i];
      check("osc_mode", 16'(MODE_OF[i]), 16'(osc_mode));
      check("startup", 16'(m <= 3), 16'(startup_delay_needed));
      check("out_oe", 16'(m inside {4, 6, 8}), 16'(osc_out_pin_oe));
      check("six_gpio", 16'(m inside {5, 7, 9}), 16'(port_a_bit_six_gpio));
      check("seven_gpio", 16'(m inside {6, 7}), 16'(port_a_bit_seven_gpio));
      check("in_oe", 16'(m inside {6, 7}), 16'(osc_in_pin_oe));
      check("in_o", 16'(m inside {6, 7}), 16'(osc_in_pin_o));
      check("mult", 16'(m inside {3, 6, 7}), 16'(multiplier_active));
      check("mult_rd", 16'(m inside {6, 7}), 16'(multiplier_enable_rd));
      check("source", 16'(m inside {6, 7} ? osc_select_pkg::src_fast : osc_select_pkg::src_pin),
            16'(clk_source));
      check("slow_en", 16'h0, 16'(slow_osc_enable));
      if (m inside {5, 7, 9}) begin
        check("six_mirror", 16'h1, 16'(osc_out_pin_o));
        check("six_in", 16'h1, 16'(port_a_bit_six_in));
        @(posedge clock) six_drive <= '{out: 1'b0, oe: 1'b1};
        repeat (8) @(negedge clock);
        check("six_oe", 16'h1, 16'(osc_out_pin_oe));
        check("six_loop", 16'h0, 16'(port_a_bit_six_in));
        @(posedge clock) six_drive <= '{out: 1'b1, oe: 1'b0};
      end
      if (m inside {6, 7}) check("seven_in", 16'h1, 16'(port_a_bit_seven_in));
      if (m inside {4, 8, 9}) measure(1'b0, 2 * PIN_HALF, "pin_tick");
      if (m inside {4, 6, 8}) measure(1'b1, (m == 6 ? FAST_DIV : 2 * PIN_HALF) * 4, "clock_out");
    end
    // Crystal x4 mode ignores the software bit
    boot(4'h6);
    @(posedge clock) mult_en <= 1'b0;
    repeat (4) @(negedge clock);
    check("mult_hw", 16'h1, 16'(multiplier_active));
    check("mult_rd_hw", 16'h0, 16'(multiplier_enable_rd));
    // Internal clock-out mode: frequency sweep, late strap change
    boot(4'h9);
    @(posedge clock);
    mult_en <= 1'b1;
    strap   <= 4'h0;
    for (f = 7; f >= -1; f--) begin
      @(posedge clock);
      freq   <= 3'(f < 0 ? 0 : f);
      origin <= (f >= 0);
      wait_src(f < 0 ? osc_select_pkg::src_slow : osc_select_pkg::src_fast);
      repeat (4) @(negedge clock);
      check("fast_en", 16'(f >= 0), 16'(fast_osc_enable));
      check("slow_en", 16'(f < 0), 16'(slow_osc_enable));
      check("mult", 16'(f >= 6), 16'(multiplier_active));
      check("mode_kept", 16'(osc_select_pkg::internal_osc_clkout_mode), 16'(osc_mode));
      measure(1'b0, f < 0 ? SLOW_DIV : FAST_DIV << (f == 0 ? 8 : 7 - f), "dev_tick");
    end
    // Slow source follows each of its users
    @(posedge clock) freq <= 3'h7;
    wait_src(osc_select_pkg::src_fast);
    for (i = 0; i < 5; i++) begin
      @(posedge clock) users <= osc_select_pkg::slow_users_t'(4'(i < 4 ? 1 << i : 0));
      repeat (3) @(negedge clock);
      check("slow_users", 16'(i < 4), 16'(slow_osc_enable));
    end
    end_sim();
  end
endmodule // osc_mode_select_tb
